// [rtl/configurable_pll_clock_manager.v]
// Behavioural clock manager with up to four independent PLL channels.
// Assumes clock pins are sampled as synchronous levels on the reference clock.
`include "pll_clock_manager_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module configurable_pll_clock_manager #(
	parameter NUM_PLL = 4,
	parameter LVDS_PLLS = 2,
	parameter [7:0] GAP_MAX = 8'h40,
	parameter DLY_DEPTH = 255
) (
	// Clock and reset.
	input wire i_ref_clk,
	input wire i_nrst,
	// Device-wide configuration state.
	input wire i_family_enh,
	input wire i_config_done,
	// Clock pins and source selection.
	input wire [NUM_PLL-1:0] i_primary_clock_input,
	input wire [NUM_PLL-1:0] i_secondary_clock_input,
	input wire [NUM_PLL-1:0] i_src_sel,
	input wire [NUM_PLL-1:0] i_both_used,
	// Base family multiplier codes.
	input wire [2*NUM_PLL-1:0] i_boost0,
	input wire [2*NUM_PLL-1:0] i_boost1,
	// Enhanced family dividers.
	input wire [8*NUM_PLL-1:0] i_mult,
	input wire [5*NUM_PLL-1:0] i_prediv,
	input wire [8*NUM_PLL-1:0] i_post0,
	input wire [5*NUM_PLL-1:0] i_post1,
	// Phase and delay shift.
	input wire [2*NUM_PLL-1:0] i_phase_sel,
	input wire [8*NUM_PLL-1:0] i_delay,
	input wire [NUM_PLL-1:0] i_delay_adv,
	// LVDS capture mode.
	input wire [NUM_PLL-1:0] i_lvds_mode,
	input wire [4*NUM_PLL-1:0] i_lvds_factor,
	// External clock and feedback.
	input wire [NUM_PLL-1:0] i_ext_fb,
	input wire [NUM_PLL-1:0] i_fb_ext_sel,
	input wire [NUM_PLL-1:0] i_ext_clk_en,
	// Lock pin sharing.
	input wire [NUM_PLL-1:0] i_lock_used,
	input wire [NUM_PLL-1:0] i_user_pin_out,
	input wire [NUM_PLL-1:0] i_user_pin_oe,
	// Generated clocks and status.
	output wire [NUM_PLL-1:0] o_clk0,
	output wire [NUM_PLL-1:0] o_clk1,
	output wire [NUM_PLL-1:0] o_ext_clk,
	output wire [NUM_PLL-1:0] o_ext_clk_oe,
	output wire [NUM_PLL-1:0] o_lock,
	output wire [NUM_PLL-1:0] o_lock_pin_out,
	output wire [NUM_PLL-1:0] o_lock_pin_oe,
	output wire [NUM_PLL-1:0] o_cfg_err
);

	localparam integer LOCK_CYC = `PCM_LOCK_CYCLES - 1;
	localparam [7:0] LOCK_LAST = LOCK_CYC[7:0];

	// Adds input credit and spends one quarter period of output when enough is held.
	function [13:0] credit_step;
		input [12:0] cr;
		input [9:0] add;
		input [12:0] dv;
		reg [13:0] sum;
		begin
			sum = {1'b0, cr} + {4'h0, add};
			if (sum > {1'b0, `PCM_CREDIT_CAP})
				sum = {1'b0, `PCM_CREDIT_CAP};
			if (sum >= {1'b0, dv})
				credit_step = {1'b1, sum[12:0] - dv};
			else
				credit_step = {1'b0, sum[12:0]};
		end
	endfunction

	function [7:0] boost_mult;
		input [1:0] code;
		begin
			case (code)
				`PCM_BOOST_X1: boost_mult = `PCM_MUL_X1;
				`PCM_BOOST_X2: boost_mult = `PCM_MUL_X2;
				default: boost_mult = `PCM_MUL_X4;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < NUM_PLL; g = g + 1) begin : pll
			wire [7:0] m_cfg = i_mult[8*g +: 8];
			wire [4:0] n_cfg = i_prediv[5*g +: 5];
			wire [7:0] k_cfg = i_post0[8*g +: 8];
			wire [4:0] v_cfg = i_post1[5*g +: 5];
			wire [1:0] b0 = i_boost0[2*g +: 2];
			wire [1:0] b1 = i_boost1[2*g +: 2];
			wire [7:0] dly = i_delay[8*g +: 8];
			wire lvds_on = i_lvds_mode[g] & (g < LVDS_PLLS);
			wire use_sec = i_both_used[g] | (i_src_sel[g] == `PCM_SRC_SECONDARY);
			wire in_lvl = use_sec ? i_secondary_clock_input[g] : i_primary_clock_input[g];
			wire in_open = i_family_enh ? i_config_done : 1'b1;
			reg in_d_r;
			reg fb_d_r;
			wire in_edge = in_lvl & ~in_d_r & in_open;
			wire fb_edge = i_ext_fb[g] & ~fb_d_r;
			wire enh_bad = (m_cfg < `PCM_MK_MIN) | (m_cfg > `PCM_MK_MAX) |
				(k_cfg < `PCM_MK_MIN) | (k_cfg > `PCM_MK_MAX) |
				(n_cfg < `PCM_NV_MIN) | (n_cfg > `PCM_NV_MAX) |
				(v_cfg < `PCM_NV_MIN) | (v_cfg > `PCM_NV_MAX);
			wire base_bad = (b0 > `PCM_BOOST_X4) | (b1 > `PCM_BOOST_X4) | (b0 > b1);
			wire src_bad = i_both_used[g] & (i_src_sel[g] == `PCM_SRC_PRIMARY);
			wire err = i_family_enh ? enh_bad : (base_bad | src_bad);
			wire [12:0] nk = {8'h00, n_cfg} * {5'h00, k_cfg};
			wire [12:0] nv = {8'h00, n_cfg} * {8'h00, v_cfg};
			wire [7:0] mul0 = lvds_on ? {4'h0, i_lvds_factor[4*g +: 4]} :
				(i_family_enh ? m_cfg : boost_mult(b0));
			wire [12:0] div0 = (lvds_on | ~i_family_enh) ? `PCM_DIV_ONE : nk;
			wire [7:0] mul1 = i_family_enh ? m_cfg : boost_mult(b1);
			wire [12:0] div1 = i_family_enh ? nv : `PCM_DIV_ONE;
			wire [9:0] add0 = in_edge ? {mul0, 2'b00} : 10'h000;
			wire [9:0] add1 = in_edge ? {mul1, 2'b00} : 10'h000;
			reg [12:0] cr0_r;
			reg [12:0] cr1_r;
			wire [13:0] st0 = credit_step(cr0_r, add0, div0);
			wire [13:0] st1 = credit_step(cr1_r, add1, div1);
			reg [1:0] q0_r;
			reg [1:0] q1_r;
			wire [1:0] ph0 = q0_r + i_phase_sel[2*g +: 2];
			wire [1:0] ph1 = q1_r + i_phase_sel[2*g +: 2];
			reg [DLY_DEPTH-1:0] dl_r;
			reg [7:0] per_cnt_r;
			reg [7:0] per_r;
			reg raw_d_r;
			wire [7:0] d_lim = (dly > per_r) ? per_r : dly;
			wire [7:0] tap = i_delay_adv[g] ? (per_r - d_lim) : d_lim;
			wire [7:0] tap_m1 = tap - 8'h01;
			wire clk0_dly = (tap == 8'h00) ? ph0[1] : dl_r[tap_m1];
			reg [7:0] gap_r;
			reg [7:0] fb_gap_r;
			reg [7:0] settle_r;
			wire lost = (gap_r >= GAP_MAX) | err |
				(i_fb_ext_sel[g] & (fb_gap_r >= GAP_MAX));
			reg clk0_r;
			reg clk1_r;
			reg ext_r;
			reg ext_oe_r;
			reg lock_r;
			reg pin_out_r;
			reg pin_oe_r;
			reg err_r;

			always @(posedge i_ref_clk) begin
				if (!i_nrst) begin
					in_d_r <= 1'b0;
					fb_d_r <= 1'b0;
					cr0_r <= 13'h0000;
					cr1_r <= 13'h0000;
					q0_r <= 2'h0;
					q1_r <= 2'h0;
					dl_r <= {DLY_DEPTH{1'b0}};
					per_cnt_r <= 8'h00;
					per_r <= 8'h00;
					raw_d_r <= 1'b0;
					gap_r <= GAP_MAX;
					fb_gap_r <= GAP_MAX;
					settle_r <= 8'h00;
					clk0_r <= 1'b0;
					clk1_r <= 1'b0;
					ext_r <= 1'b0;
					ext_oe_r <= 1'b0;
					lock_r <= 1'b0;
					pin_out_r <= 1'b0;
					pin_oe_r <= 1'b0;
					err_r <= 1'b0;
				end else begin
					in_d_r <= in_lvl;
					fb_d_r <= i_ext_fb[g];
					if (err) begin
						cr0_r <= 13'h0000;
						cr1_r <= 13'h0000;
					end else begin
						cr0_r <= st0[12:0];
						cr1_r <= st1[12:0];
						q0_r <= q0_r + {1'b0, st0[13]};
						q1_r <= q1_r + {1'b0, st1[13]};
					end
					dl_r <= {dl_r[DLY_DEPTH-2:0], ph0[1]};
					raw_d_r <= ph0[1];
					// Output period in reference cycles bounds the delay shift.
					if (ph0[1] & ~raw_d_r) begin
						per_r <= per_cnt_r;
						per_cnt_r <= 8'h01;
					end else if (per_cnt_r != 8'hFF) begin
						per_cnt_r <= per_cnt_r + 8'h01;
					end
					if (in_edge)
						gap_r <= 8'h00;
					else if (gap_r < GAP_MAX)
						gap_r <= gap_r + 8'h01;
					if (fb_edge)
						fb_gap_r <= 8'h00;
					else if (fb_gap_r < GAP_MAX)
						fb_gap_r <= fb_gap_r + 8'h01;
					if (lost) begin
						settle_r <= 8'h00;
						lock_r <= 1'b0;
					end else if (settle_r == LOCK_LAST) begin
						lock_r <= 1'b1;
					end else begin
						settle_r <= settle_r + 8'h01;
					end
					clk0_r <= clk0_dly;
					clk1_r <= ph1[1];
					ext_r <= clk0_r;
					ext_oe_r <= i_ext_clk_en[g];
					pin_out_r <= i_lock_used[g] ? (lock_r & ~lost) : i_user_pin_out[g];
					pin_oe_r <= i_lock_used[g] | i_user_pin_oe[g];
					err_r <= err;
				end
			end

			assign o_clk0[g] = clk0_r;
			assign o_clk1[g] = clk1_r;
			assign o_ext_clk[g] = ext_r;
			assign o_ext_clk_oe[g] = ext_oe_r;
			assign o_lock[g] = lock_r;
			assign o_lock_pin_out[g] = pin_out_r;
			assign o_lock_pin_oe[g] = pin_oe_r;
			assign o_cfg_err[g] = err_r;
		end
	endgenerate

endmodule // configurable_pll_clock_manager

`default_nettype wire

// [rtl/pll_clock_manager_regs.vh]
// Constants shared by the clock manager: divider limits, encodings and timing.
// Assumes the includer runs on the 50 ns reference clock.
`ifndef PLL_CLOCK_MANAGER_REGS_VH
`define PLL_CLOCK_MANAGER_REGS_VH

`define PCM_MK_MIN 8'h02
`define PCM_MK_MAX 8'hA0
`define PCM_NV_MIN 5'h01
`define PCM_NV_MAX 5'h10

`define PCM_BOOST_X1 2'h0
`define PCM_BOOST_X2 2'h1
`define PCM_BOOST_X4 2'h2
`define PCM_MUL_X1 8'h01
`define PCM_MUL_X2 8'h02
`define PCM_MUL_X4 8'h04

`define PCM_SRC_PRIMARY 1'h0
`define PCM_SRC_SECONDARY 1'h1

`define PCM_LOCK_TIME_NS 10000
`define PCM_REF_PERIOD_NS 50
`define PCM_LOCK_CYCLES (`PCM_LOCK_TIME_NS / `PCM_REF_PERIOD_NS)

`define PCM_CREDIT_CAP 13'h0FFF
`define PCM_DIV_ONE 13'h0001

`endif

// [tb/pll_clock_manager_monitor.sv]
// Port checker for the clock manager, lane 0; the reset check covers every lock output.
// Assumes it is bound to the top module.
`timescale 1ns/100ps
`default_nettype none
module pll_clock_manager_monitor #(parameter NUM_PLL = 4) (
	// Watched ports.
	input wire i_ref_clk,
	input wire i_nrst,
	input wire i_family_enh,
	input wire i_config_done,
	input wire [NUM_PLL-1:0] i_src_sel,
	input wire [NUM_PLL-1:0] i_both_used,
	input wire [2*NUM_PLL-1:0] i_boost0,
	input wire [2*NUM_PLL-1:0] i_boost1,
	input wire [8*NUM_PLL-1:0] i_mult,
	input wire [NUM_PLL-1:0] i_ext_clk_en,
	input wire [NUM_PLL-1:0] i_lock_used,
	input wire [NUM_PLL-1:0] i_user_pin_out,
	input wire [NUM_PLL-1:0] i_user_pin_oe,
	input wire [NUM_PLL-1:0] o_clk0,
	input wire [NUM_PLL-1:0] o_ext_clk,
	input wire [NUM_PLL-1:0] o_lock_pin_oe,
	input wire [NUM_PLL-1:0] o_ext_clk_oe,
	input wire [NUM_PLL-1:0] o_lock,
	input wire [NUM_PLL-1:0] o_lock_pin_out,
	input wire [NUM_PLL-1:0] o_cfg_err
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_boost_bad;
		!i_family_enh && i_boost0[1:0] > i_boost1[1:0];
	endsequence
	sequence s_mult_bad;
		i_family_enh && (i_mult[7:0] < 8'h02 || i_mult[7:0] > 8'hA0);
	endsequence
	a_boost_order: assert property (s_boost_bad |=> o_cfg_err[0]) else $error("boost");
	a_shared_pin: assert property (!i_family_enh && i_both_used[0] && !i_src_sel[0]
		|=> o_cfg_err[0]) else $error("shared");
	a_mult_range: assert property (s_mult_bad |=> o_cfg_err[0]) else $error("mult");
	a_err_unlock: assert property (o_cfg_err[0] |=> !o_lock[0]) else $error("err lock");
	a_reset_low: assert property ($rose(i_nrst) |-> o_lock == 0) else $error("rst lock");
	a_wait_config: assert property ($rose(o_lock[0]) |-> !i_family_enh || $past(i_config_done))
		else $error("cfg lock");
	a_ext_enable: assert property ($past(i_nrst) |-> o_ext_clk_oe[0] == $past(i_ext_clk_en[0]))
		else $error("ext oe");
	a_user_pin: assert property ($past(i_nrst) && !i_lock_used[0] && !$past(i_lock_used[0])
		|-> o_lock_pin_out[0] == $past(i_user_pin_out[0])) else $error("pin");
	a_ext_follow: assert property ($past(i_nrst) |-> o_ext_clk[0] == $past(o_clk0[0]))
		else $error("ext clk");
	a_pin_enable: assert property ($past(i_nrst) |->
		o_lock_pin_oe[0] == ($past(i_lock_used[0]) || $past(i_user_pin_oe[0])))
		else $error("pin oe");
endmodule // pll_clock_manager_monitor
bind configurable_pll_clock_manager pll_clock_manager_monitor #(.NUM_PLL(NUM_PLL)) mon (.*);
`default_nettype wire

// [tb/clk_source.sv]
// Board clock source model, HALF reference cycles per half period.
// Assumes a free reference clock; the pin stands low while stopped.
`timescale 1ns/100ps
`default_nettype none
module clk_source #(
	parameter int HALF = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_run,
	output logic o_pin = 1'b0
);
	int cnt = 0;
	always @(posedge i_ref_clk) begin
		if (!i_run) begin
			o_pin <= 1'b0;
			cnt <= 0;
		end else if (cnt == HALF - 1) begin
			o_pin <= ~o_pin;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // clk_source
`default_nettype wire

// [tb/configurable_pll_clock_manager_tb.sv]
// Self-checking bench of the clock manager with two lanes.
// Assumes the source model and the bound checker are compiled with it.
`timescale 1ns/100ps
`default_nettype none
module configurable_pll_clock_manager_tb;
	localparam int WIN = 64;
	localparam int LOCK_LIMIT = 10000 / 50 + 2;
	logic i_ref_clk = 0, i_nrst = 0, enh = 0, done = 0, run = 0, pin, spin;
	logic [63:0] r = 0;
	logic [31:0] s = 32'hE8F481C9;
	logic [15:0] mv = 16'h0808;
	logic [9:0] vv = 10'h042;
	logic [7:0] mt[4] = '{8'h01, 8'h02, 8'hA0, 8'hA1};
	logic [7:0] cnt[4];
	logic [1:0] lock, err, pout, eoe, c0, c1, lv = 2'h0;
	int num_errors = 0, checked = 0, n;
	always #25 i_ref_clk = ~i_ref_clk;
	clk_source #(.HALF(1)) src (.i_ref_clk(i_ref_clk), .i_run(run), .o_pin(pin));
	// The slow source stands in for a low-rate interface clock on the secondary pin.
	clk_source #(.HALF(4)) slow_src (.i_ref_clk(i_ref_clk), .i_run(run), .o_pin(spin));
	configurable_pll_clock_manager #(.NUM_PLL(2), .GAP_MAX(8'h08)) uut (.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst), .i_family_enh(enh), .i_config_done(done),
		.i_primary_clock_input({2{pin}}), .i_secondary_clock_input({2{spin}}),
		.i_src_sel(r[1:0]), .i_both_used(r[3:2]), .i_boost0(r[7:4]), .i_boost1(r[11:8]),
		.i_mult(mv), .i_prediv(10'h021), .i_post0(16'h0404), .i_post1(vv),
		.i_phase_sel(r[53:50]), .i_delay(r[31:16]), .i_delay_adv(r[15:14]),
		.i_lvds_mode(lv), .i_lvds_factor(r[39:32]), .i_ext_fb({2{pin}}),
		.i_fb_ext_sel(r[41:40]), .i_ext_clk_en(r[43:42]), .i_lock_used(r[45:44]),
		.i_user_pin_out(r[47:46]), .i_user_pin_oe(r[49:48]), .o_clk0(c0), .o_clk1(c1),
		.o_ext_clk(), .o_ext_clk_oe(eoe), .o_lock(lock), .o_lock_pin_out(pout),
		.o_lock_pin_oe(), .o_cfg_err(err));
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [1:0] base_err(input logic [63:0] v);
		logic [1:0] e;
		for (int g = 0; g < 2; g++) begin
			e[g] = v[4+2*g+:2] == 2'h3 || v[8+2*g+:2] == 2'h3 || v[4+2*g+:2] > v[8+2*g+:2]
				|| (v[2+g] && !v[g]);
		end
		return e;
	endfunction
	// Rising edges expected in WIN cycles for an input period of per cycles and mul over div.
	function automatic logic [7:0] exp_edges(input int per, input int mul, input int div);
		return 8'(WIN * mul / (div * per));
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge i_ref_clk);
	endtask
	task automatic wait_lock(output int k);
		k = 0;
		while (lock !== 2'h3 && k < 260) begin
			cyc(1);
			k++;
		end
	endtask
	// Counts rising edges of both generated clocks of both lanes over WIN cycles.
	task automatic count_edges();
		logic [3:0] prev;
		logic [3:0] now;
		prev = {c1, c0};
		for (int j = 0; j < 4; j++) begin
			cnt[j] = 8'h00;
		end
		repeat (WIN) begin
			cyc(1);
			now = {c1, c0};
			for (int j = 0; j < 4; j++) begin
				cnt[j] = cnt[j] + {7'h00, now[j] & ~prev[j]};
			end
			prev = now;
		end
	endtask
	initial begin
		cyc(10);
		i_nrst = 1;
		cyc(1);
		chk(lock, 2'h0);
		for (int i = 0; i < 24; i++) begin
			s = lfsr(s);
			r[31:0] = (i == 0) ? 32'h000004A4 : s;
			cyc(2);
			chk(err, base_err(r));
		end
		$display("base codes done");
		enh = 1;
		foreach (mt[i]) begin
			mv = {2{mt[i]}};
			cyc(2);
			chk(err, {2{mt[i] < 8'h02 || mt[i] > 8'hA0}});
		end
		mv = 16'h0808;
		vv = 10'h220;
		cyc(2);
		chk(err, 2'h3);
		$display("divider ranges done");
		mv = 16'h0202;
		vv = 10'h108;
		r[3:0] = 4'h0;
		r[53:40] = s[13:0];
		run = 1;
		cyc(300);
		chk(lock, 2'h0);
		done = 1;
		wait_lock(n);
		chk(n <= LOCK_LIMIT, 8'h01);
		cyc(2);
		chk(pout, (lock & r[45:44]) | (r[47:46] & ~r[45:44]));
		chk(eoe, r[43:42]);
		count_edges();
		chk(cnt[0], exp_edges(2, 2, 4));
		chk(cnt[1], exp_edges(2, 2, 4));
		chk(cnt[2], exp_edges(2, 2, 8));
		chk(cnt[3], exp_edges(2, 2, 8));
		$display("enhanced lock done");
		r[3:0] = 4'h3;
		r[39:32] = 8'h22;
		lv = 2'h3;
		cyc(40);
		count_edges();
		chk(cnt[0], exp_edges(8, 2, 1));
		chk(cnt[1], exp_edges(8, 2, 1));
		chk(cnt[2], exp_edges(8, 2, 8));
		chk(cnt[3], exp_edges(8, 2, 8));
		$display("capture clock done");
		run = 0;
		cyc(12);
		chk(lock, 2'h0);
		$display("lock loss done");
		enh = 0;
		done = 0;
		lv = 2'h0;
		r[11:0] = 12'h000;
		run = 1;
		wait_lock(n);
		chk(n <= LOCK_LIMIT, 8'h01);
		i_nrst = 0;
		cyc(2);
		chk(lock, 2'h0);
		i_nrst = 1;
		cyc(2);
		chk(lock, 2'h0);
		$display("base lock done");
		wrap_up();
	end
endmodule // configurable_pll_clock_manager_tb
`default_nettype wire
